// >>> core/stop_mode_standby_control.sv
// Deep standby controller with AHB-Lite register access
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "standby_consts.svh"

module stop_mode_standby_control
    import standby_pkg::*;
#(
    parameter int IRQ_N       = 8,
    parameter int PORT_W      = 8,
    parameter int STAB_CYCLES = `STAB_CYCLES,
    parameter int WAIT_VEC    = `WAIT_VECTOR_CLKS,
    parameter int WAIT_SEQ    = `WAIT_SEQ_CLKS
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              stop_exec,
    input  wire logic [IRQ_N-1:0]  irq_req,
    input  wire logic [IRQ_N-1:0]  irq_mask,
    input  wire logic              irq_ack_enable,
    input  wire logic              reset_req,
    input  wire logic              wdt_standby_run,
    input  wire logic              wdt_enable_option,
    input  wire logic              port_wr,
    input  wire logic [PORT_W-1:0] port_wr_data,
    output logic [PORT_W-1:0]      port_out,
    output logic                   cpu_clk_en,
    output logic                   cpu_halt,
    output logic                   flash_halt,
    output logic                   ram_halt,
    output logic                   hs_osc_en,
    output logic                   ls_osc_en,
    output logic                   wdt_run_en,
    output logic                   wake_detect_en,
    output logic                   stop_active,
    output logic                   vector_start,
    output logic                   next_instr_start,
    output logic                   reset_vector_start
);

    localparam int CNT_W = `DELAY_CNT_W;

    // =================================================================
    // Declarations
    standby_state_t         state;
    standby_state_t         next_state;
    logic                   wake_pending;
    logic                   vec_sel;
    logic                   next_vec_sel;
    logic                   interval_timer_clk_sel;
    logic                   ls_osc_standby;
    logic                   in_standby;
    logic                   next_in_standby;
    logic                   dly_load;
    logic [CNT_W-1:0]       dly_val;
    logic                   dly_last;
    logic [`REL_COUNT_W-1:0] release_count;
    logic                   ap_valid;
    logic                   ap_write;
    logic [7:0]             ap_addr;
    logic                   dp_write;
    logic [7:0]             dp_addr;
    logic [31:0]            next_hrdata;

    // =================================================================
    // Helpers
    function automatic logic standby_state(input standby_state_t s);
        standby_state = (s == ST_STOP) || (s == ST_STAB);
    endfunction : standby_state

    function automatic logic [CNT_W-1:0] wait_count(input logic vec);
        wait_count = vec ? CNT_W'(WAIT_VEC) : CNT_W'(WAIT_SEQ);
    endfunction : wait_count

    // =================================================================
    // Wake request detection
    // Any request whose mask flag is clear wakes the sequencer
    assign wake_pending = |(irq_req & ~irq_mask);

    // Low-speed oscillator decision while clocks are stopped
    always_comb begin
        if (interval_timer_clk_sel) begin
            ls_osc_standby = 1'b1;
        end else if (!wdt_enable_option) begin
            ls_osc_standby = 1'b0;
        end else begin
            ls_osc_standby = wdt_standby_run;
        end
    end

    // =================================================================
    // Sequencer next state
    always_comb begin
        next_state   = state;
        next_vec_sel = vec_sel;
        dly_load     = 1'b0;
        dly_val      = '0;
        case (state)
            ST_RUN: begin
                if (stop_exec) begin
                    if (wake_pending) begin
                        next_state   = ST_STAB;
                        next_vec_sel = irq_ack_enable;
                        dly_load     = 1'b1;
                        dly_val      = CNT_W'(STAB_CYCLES);
                    end else begin
                        next_state   = ST_STOP;
                    end
                end
            end
            ST_STOP: begin
                if (wake_pending) begin
                    next_state   = ST_STAB;
                    next_vec_sel = irq_ack_enable;
                    dly_load     = 1'b1;
                    dly_val      = CNT_W'(STAB_CYCLES);
                end
            end
            ST_STAB: begin
                if (dly_last) begin
                    next_state = ST_WAIT;
                    dly_load   = 1'b1;
                    dly_val    = wait_count(vec_sel);
                end
            end
            ST_WAIT: begin
                if (dly_last) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
        if (reset_req) begin
            next_state   = ST_RUN;
            next_vec_sel = 1'b0;
            dly_load     = 1'b1;
            dly_val      = '0;
        end
    end

    assign next_in_standby = standby_state(next_state);

    // =================================================================
    // State register
    // Vector choice is taken at the wake edge and held through the resume wait
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state   <= ST_RUN;
            vec_sel <= 1'b0;
        end else begin
            state   <= next_state;
            vec_sel <= next_vec_sel;
        end
    end

    // One shared counter times both the clock-off interval and the resume wait
    standby_delay_counter #(
        .CNT_W    (CNT_W)
    ) u_delay (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .load     (dly_load),
        .load_val (dly_val),
        .busy     (),
        .last     (dly_last)
    );

    // =================================================================
    // Clock and power controls, registered from the next state
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            in_standby  <= 1'b0;
            stop_active <= 1'b0;
            cpu_clk_en  <= 1'b1;
            cpu_halt    <= 1'b0;
            flash_halt  <= 1'b0;
            ram_halt    <= 1'b0;
            hs_osc_en   <= 1'b1;
        end else begin
            in_standby  <= next_in_standby;
            stop_active <= (next_state == ST_STOP);
            cpu_clk_en  <= !next_in_standby;
            cpu_halt    <= (next_state != ST_RUN);
            flash_halt  <= (next_state != ST_RUN);
            ram_halt    <= (next_state != ST_RUN);
            hs_osc_en   <= (next_state != ST_STOP);
        end
    end

    // Oscillator and watchdog run enables follow live option levels in standby and are forced on otherwise
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ls_osc_en  <= 1'b1;
            wdt_run_en <= 1'b1;
        end else if (next_in_standby) begin
            ls_osc_en  <= ls_osc_standby;
            wdt_run_en <= wdt_standby_run;
        end else begin
            ls_osc_en  <= 1'b1;
            wdt_run_en <= 1'b1;
        end
    end

    // Wake sources are never gated by standby
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wake_detect_en <= 1'b1;
        end else begin
            wake_detect_en <= 1'b1;
        end
    end

    // =================================================================
    // Execution restart pulses
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vector_start       <= 1'b0;
            next_instr_start   <= 1'b0;
            reset_vector_start <= 1'b0;
        end else begin
            vector_start       <= 1'b0;
            next_instr_start   <= 1'b0;
            reset_vector_start <= reset_req;
            if (!reset_req && state == ST_WAIT && dly_last) begin
                vector_start     <= vec_sel;
                next_instr_start <= !vec_sel;
            end
        end
    end

    // Count interrupt releases for software
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            release_count <= '0;
        end else if (!reset_req && state == ST_WAIT && dly_last) begin
            release_count <= release_count + `REL_COUNT_W'(1);
        end
    end

    // =================================================================
    // Port output latches, frozen outside normal run
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_out <= '0;
        end else if (port_wr && state == ST_RUN && !stop_exec) begin
            port_out <= port_wr_data;
        end
    end

    // =================================================================
    // AHB-Lite address phase
    assign ap_valid = hsel && hready && htrans[1];
    assign ap_write = ap_valid && hwrite && (hsize == `HSIZE_WORD);
    assign ap_addr  = haddr[7:0];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= ap_write;
            dp_addr  <= ap_addr;
        end
    end

    // =================================================================
    // AHB-Lite write data phase
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            interval_timer_clk_sel <= `SPEED_MODE_CTRL_RST;
        end else if (dp_write && dp_addr == `OFS_SPEED_MODE_CTRL) begin
            interval_timer_clk_sel <= hwdata[`ITCS_BIT];
        end
    end

    // =================================================================
    // AHB-Lite read data, captured at the address phase
    always_comb begin
        next_hrdata = 32'h0000_0000;
        case (ap_addr)
            `OFS_SPEED_MODE_CTRL: begin
                next_hrdata[`ITCS_BIT] = interval_timer_clk_sel;
            end
            `OFS_STANDBY_STATUS: begin
                next_hrdata[`ST_STATE_LSB +: 3] = state;
                next_hrdata[`ST_LS_OSC_BIT]     = ls_osc_en;
                next_hrdata[`ST_WDT_RUN_BIT]    = wdt_run_en;
                next_hrdata[`ST_HS_OSC_BIT]     = hs_osc_en;
                next_hrdata[`ST_VEC_SEL_BIT]    = vec_sel;
                next_hrdata[`ST_PORT_HOLD_BIT]  = in_standby;
            end
            `OFS_RELEASE_COUNT: begin
                next_hrdata[`REL_COUNT_W-1:0] = release_count;
            end
            default: begin
                next_hrdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_valid && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = `HRESP_OKAY;

endmodule : stop_mode_standby_control

// >>> core/standby_consts.svh
// Constants for the deep standby controller: register map, fields, timing
`ifndef STANDBY_CONSTS_SVH
`define STANDBY_CONSTS_SVH

// =====================================================================
// Register byte offsets
`define OFS_SPEED_MODE_CTRL   8'h00
`define OFS_STANDBY_STATUS    8'h04
`define OFS_RELEASE_COUNT     8'h08

// =====================================================================
// Field positions and reset values
`define ITCS_BIT              4
`define SPEED_MODE_CTRL_RST   1'h0
`define ST_STATE_LSB          0
`define ST_LS_OSC_BIT         3
`define ST_WDT_RUN_BIT        4
`define ST_HS_OSC_BIT         5
`define ST_VEC_SEL_BIT        6
`define ST_PORT_HOLD_BIT      7
`define REL_COUNT_W           16

// =====================================================================
// AHB-Lite encodings
`define HSIZE_WORD            3'h2
`define HRESP_OKAY            1'h0

// =====================================================================
// Timing
`define CLK_FREQ_KHZ          40000
`define STAB_TIME_NS          27000
`define STAB_CYCLES           ((`STAB_TIME_NS * `CLK_FREQ_KHZ + 999999) / 1000000)
`define WAIT_VECTOR_CLKS      11
`define WAIT_SEQ_CLKS         3
`define DELAY_CNT_W           12

`endif

// >>> core/standby_pkg.sv
// Types shared by the deep standby controller
package standby_pkg;

    // =================================================================
    // Controller states
    typedef enum logic [2:0] {
        ST_RUN  = 3'b000,
        ST_STOP = 3'b001,
        ST_STAB = 3'b010,
        ST_WAIT = 3'b011
    } standby_state_t;

endpackage : standby_pkg

// >>> core/standby_delay_counter.sv
// Loadable down counter that marks the last cycle of a programmed interval
`timescale 1ns/1ps
`include "standby_consts.svh"

module standby_delay_counter #(
    parameter int CNT_W = `DELAY_CNT_W
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    output logic                  busy,
    output logic                  last
);

    logic [CNT_W-1:0] count;

    // =================================================================
    // Counter
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (load) begin
            count <= load_val;
        end else if (count != '0) begin
            count <= count - CNT_W'(1);
        end
    end

    assign busy = (count != '0);
    assign last = (count == CNT_W'(1));

endmodule : standby_delay_counter

// >>> bench/standby_chk.sv
// Port-level checker for the deep standby controller
`timescale 1ns/1ps
module standby_chk #(
    parameter int IRQ_N       = 8,
    parameter int PORT_W      = 8,
    parameter int STAB_CYCLES = 1080,
    parameter int WAIT_VEC    = 11,
    parameter int WAIT_SEQ    = 3
) (
    input wire logic              core_clk,
    input wire logic              sys_rst,
    input wire logic              stop_exec,
    input wire logic [IRQ_N-1:0]  irq_req,
    input wire logic [IRQ_N-1:0]  irq_mask,
    input wire logic              reset_req,
    input wire logic              wdt_standby_run,
    input wire logic              wdt_enable_option,
    input wire logic [PORT_W-1:0] port_out,
    input wire logic              cpu_clk_en,
    input wire logic              cpu_halt,
    input wire logic              flash_halt,
    input wire logic              ram_halt,
    input wire logic              hs_osc_en,
    input wire logic              ls_osc_en,
    input wire logic              wdt_run_en,
    input wire logic              wake_detect_en,
    input wire logic              stop_active,
    input wire logic              vector_start,
    input wire logic              next_instr_start,
    input wire logic              reset_vector_start
);
    logic [15:0] stab_cnt;
    logic [15:0] wait_cnt;
    logic        pend;
    assign pend = |(irq_req & ~irq_mask);
    // ====================================================================
    // Length of the clock-off interval after release and of the resume wait
    always_ff @(posedge core_clk) begin
        stab_cnt <= (sys_rst || cpu_clk_en || stop_active) ? 16'h0000 : stab_cnt + 16'h0001;
    end
    always_ff @(posedge core_clk) begin
        wait_cnt <= (sys_rst || !cpu_clk_en || !cpu_halt) ? 16'h0000 : wait_cnt + 16'h0001;
    end
    // ====================================================================
    // Properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_entry; $rose(stop_active) |-> $past(stop_exec); endproperty
    a_entry: assert property (p_entry) else $error("standby without instruction");
    property p_pend; stop_exec && cpu_clk_en && !cpu_halt && pend && !reset_req
        |=> !stop_active && !cpu_clk_en && hs_osc_en; endproperty
    a_pend: assert property (p_pend) else $error("pending request not honoured");
    property p_gate; stop_active |-> !cpu_clk_en && cpu_halt && flash_halt && ram_halt;
    endproperty
    a_gate: assert property (p_gate) else $error("clock or halts wrong");
    property p_hs; hs_osc_en != stop_active; endproperty
    a_hs: assert property (p_hs) else $error("fast oscillator wrong");
    property p_ls; stop_active && wdt_enable_option && wdt_standby_run |-> ls_osc_en; endproperty
    a_ls: assert property (p_ls) else $error("slow oscillator stopped");
    property p_port; stop_active |-> $stable(port_out); endproperty
    a_port: assert property (p_port) else $error("port latch changed");
    property p_wdt; stop_active |-> wdt_run_en == wdt_standby_run; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog run wrong");
    property p_live; wake_detect_en; endproperty
    a_live: assert property (p_live) else $error("wake detection off");
    property p_wake; stop_active && pend && !reset_req |=> !stop_active && hs_osc_en; endproperty
    a_wake: assert property (p_wake) else $error("no release on request");
    property p_stab; $rose(cpu_clk_en) && cpu_halt |-> stab_cnt == STAB_CYCLES; endproperty
    a_stab: assert property (p_stab) else $error("stabilization length wrong");
    property p_resume; vector_start || next_instr_start
        |-> wait_cnt == (vector_start ? WAIT_VEC : WAIT_SEQ); endproperty
    a_resume: assert property (p_resume) else $error("resume wait wrong");
    property p_rst; reset_req |=> reset_vector_start && cpu_clk_en && !stop_active; endproperty
    a_rst: assert property (p_rst) else $error("reset release wrong");
endmodule : standby_chk

bind stop_mode_standby_control standby_chk #(.IRQ_N(IRQ_N), .PORT_W(PORT_W),
    .STAB_CYCLES(STAB_CYCLES), .WAIT_VEC(WAIT_VEC), .WAIT_SEQ(WAIT_SEQ)) standby_chk_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .stop_exec(stop_exec), .irq_req(irq_req),
    .irq_mask(irq_mask), .reset_req(reset_req), .wdt_standby_run(wdt_standby_run),
    .wdt_enable_option(wdt_enable_option), .port_out(port_out), .cpu_clk_en(cpu_clk_en),
    .cpu_halt(cpu_halt), .flash_halt(flash_halt), .ram_halt(ram_halt),
    .hs_osc_en(hs_osc_en), .ls_osc_en(ls_osc_en), .wdt_run_en(wdt_run_en),
    .wake_detect_en(wake_detect_en), .stop_active(stop_active), .vector_start(vector_start),
    .next_instr_start(next_instr_start), .reset_vector_start(reset_vector_start));

// >>> bench/cpu_irq_model.sv
// CPU and interrupt controller model issuing standby entry and wakeup
`timescale 1ns/1ps
module cpu_irq_model (
    input  wire logic core_clk,
    output logic       stop_exec,
    output logic [7:0] irq_req,
    output logic [7:0] irq_mask,
    output logic       irq_ack_enable,
    output logic       wdt_standby_run,
    output logic       wdt_enable_option,
    output logic       port_wr,
    output logic [7:0] port_wr_data
);
    initial begin
        {stop_exec, irq_ack_enable, port_wr, wdt_standby_run, wdt_enable_option} = 5'h03;
        {irq_req, irq_mask, port_wr_data} = 24'h00FF00;
    end
    task automatic set_opts(input logic en, input logic run);
        @(posedge core_clk);
        wdt_enable_option <= en;
        wdt_standby_run   <= run;
    endtask : set_opts
    // Software has already stopped the peripherals when the instruction runs
    task automatic issue_stop;
        @(posedge core_clk);
        stop_exec <= 1'b1;
        @(posedge core_clk);
        stop_exec <= 1'b0;
    endtask : issue_stop
    task automatic write_port(input logic [7:0] d);
        @(posedge core_clk);
        port_wr      <= 1'b1;
        port_wr_data <= d;
        @(posedge core_clk);
        port_wr      <= 1'b0;
        port_wr_data <= ~d;
    endtask : write_port
    // Request held masked for hold cycles first, then unmasked; unmasked at once when hold is 0
    task automatic wake(input logic [2:0] idx, input logic ack, input int hold);
        @(posedge core_clk);
        irq_req[idx]   <= 1'b1;
        irq_mask       <= (hold == 0) ? ~(8'h01 << idx) : 8'hFF;
        irq_ack_enable <= ack;
        repeat (hold) @(posedge core_clk);
        if (hold != 0) irq_mask[idx] <= 1'b0;
    endtask : wake
    // Peripherals with stopped clocks are restarted by software after this
    task automatic clear;
        @(posedge core_clk);
        irq_req  <= 8'h00;
        irq_mask <= 8'hFF;
    endtask : clear
endmodule : cpu_irq_model

// >>> bench/tb_top.sv
// Self-checking bench for the deep standby controller
`timescale 1ns/1ps
`include "standby_consts.svh"
module tb_top;
    localparam int STAB = 20;
    logic        core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, reset_req, stop_exec;
    logic [31:0] haddr, hwdata, hrdata, rnd, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  irq_req, irq_mask, port_wr_data, port_out, pval;
    logic        irq_ack_enable, wdt_standby_run, wdt_enable_option, port_wr, cpu_clk_en;
    logic        cpu_halt, flash_halt, ram_halt, hs_osc_en, ls_osc_en, wdt_run_en;
    logic        wake_detect_en, stop_active, vector_start, next_instr_start;
    logic        reset_vector_start;
    int          fails, checks_done, rel_cnt;
    int          exp_q[$];

    stop_mode_standby_control #(.STAB_CYCLES(STAB)) stop_mode_standby_control_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_exec(stop_exec),
        .irq_req(irq_req), .irq_mask(irq_mask), .irq_ack_enable(irq_ack_enable),
        .reset_req(reset_req), .wdt_standby_run(wdt_standby_run),
        .wdt_enable_option(wdt_enable_option), .port_wr(port_wr), .port_wr_data(port_wr_data),
        .port_out(port_out), .cpu_clk_en(cpu_clk_en), .cpu_halt(cpu_halt),
        .flash_halt(flash_halt), .ram_halt(ram_halt), .hs_osc_en(hs_osc_en),
        .ls_osc_en(ls_osc_en), .wdt_run_en(wdt_run_en), .wake_detect_en(wake_detect_en),
        .stop_active(stop_active), .vector_start(vector_start),
        .next_instr_start(next_instr_start), .reset_vector_start(reset_vector_start));
    cpu_irq_model cpu_irq_model_i (
        .core_clk(core_clk), .stop_exec(stop_exec), .irq_req(irq_req), .irq_mask(irq_mask),
        .irq_ack_enable(irq_ack_enable), .wdt_standby_run(wdt_standby_run),
        .wdt_enable_option(wdt_enable_option), .port_wr(port_wr), .port_wr_data(port_wr_data));

    always #12.5 core_clk = ~core_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task automatic hwait;
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            results();
        end
    endtask : hwait
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge core_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        hwait();
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        hwait();
        rd = hrdata;
        check(hresp, `HRESP_OKAY);
    endtask : ahb
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
        ahb(a, 1'b0, 32'h00000000);
        check(rd & m, exp);
    endtask : rd_chk
    // Counts falling edges until a start pulse; base is one or two release-edge cycles
    task automatic wait_start(input int base);
        int n;
        n = 0;
        while (vector_start !== 1'b1 && next_instr_start !== 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 3000) begin
            fails++;
            results();
        end
        check(n, base + STAB + (exp_q[0] ? `WAIT_VECTOR_CLKS : `WAIT_SEQ_CLKS));
        check(vector_start, exp_q[0]);
        check(next_instr_start, !exp_q.pop_front());
        rel_cnt++;
        rd_chk(`OFS_RELEASE_COUNT, 32'(rel_cnt), 32'h0000FFFF);
    endtask : wait_start

    initial begin
        {core_clk, sys_rst, hsel, hwrite, reset_req, htrans} = 7'h20;
        {haddr, hwdata, hsize, rnd} = {64'h0, `HSIZE_WORD, 32'h5DE0};
        {fails, checks_done, rel_cnt} = 0;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(`OFS_SPEED_MODE_CTRL, 32'h00000000, 32'hFFFFFFFF);
        rd_chk(`OFS_STANDBY_STATUS, 32'h00000038, 32'h000000FF);
        rd_chk(32'h0000000C, 32'h00000000, 32'hFFFFFFFF);
        // A byte-sized write must leave the clock select untouched
        hsize <= 3'h0;
        ahb(`OFS_SPEED_MODE_CTRL, 1'b1, 32'h00000010);
        hsize <= `HSIZE_WORD;
        rd_chk(`OFS_SPEED_MODE_CTRL, 32'h00000000, 32'hFFFFFFFF);
        check(cpu_clk_en, 1'b1);
        $display("test reset values done");
        for (int k = 0; k < 8; k++) begin
            logic       ack;
            logic       ls;
            logic [2:0] idx;
            rnd = lfsr(rnd);
            {pval, idx, ack} = {rnd[15:8], rnd[3:1], rnd[0]};
            ls = k[0] | (k[1] & k[2]);
            ahb(`OFS_SPEED_MODE_CTRL, 1'b1, {27'h0, k[0], 4'h0});
            rd_chk(`OFS_SPEED_MODE_CTRL, {27'h0, k[0], 4'h0}, 32'hFFFFFFFF);
            cpu_irq_model_i.set_opts(k[1], k[2]);
            cpu_irq_model_i.write_port(pval);
            exp_q.push_back(ack);
            if (k == 5) begin
                cpu_irq_model_i.wake(idx, ack, 0);
                cpu_irq_model_i.issue_stop();
                wait_start(1);
            end else begin
                cpu_irq_model_i.issue_stop();
                rd_chk(`OFS_STANDBY_STATUS, {24'h0, 3'h4, k[2], ls, 3'h1}, 32'hBF);
                check(ls_osc_en, ls);
                check(wdt_run_en, k[2]);
                cpu_irq_model_i.write_port(~pval);
                @(negedge core_clk);
                check(port_out, pval);
                cpu_irq_model_i.wake(idx, ack, 1 + k);
                check(stop_active, 1'b1);
                wait_start(2);
            end
            check(port_out, pval);
            cpu_irq_model_i.clear();
            $display("test %0d done", k);
        end
        cpu_irq_model_i.issue_stop();
        @(posedge core_clk);
        reset_req <= 1'b1;
        @(posedge core_clk);
        reset_req <= 1'b0;
        @(negedge core_clk);
        check(reset_vector_start, 1'b1);
        check(stop_active, 1'b0);
        $display("test reset release done");
        results();
    end
endmodule : tb_top
